// [hdl/ais_top.sv]
// Interrupt status readback: live and read-to-clear latched fault registers,
// masks, pin source select, Avalon-MM slave. Sources come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none

module ais_top
    import ais_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [BUS_W-1:0]  avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [BUS_W-1:0]  avs_readdata,
    output logic                   avs_waitrequest,
    // Limiter, clock and protection sources
    input  wire logic              lim_mute,
    input  wire logic              lim_inf_hold,
    input  wire logic              lim_max_atten,
    input  wire logic              vbat_below_inflect,
    input  wire logic              lim_active,
    input  wire logic              tdm_clk_err,
    input  wire logic              over_current,
    input  wire logic              over_temp,
    // Supply and PDM sources
    input  wire logic              pdm_data_invalid,
    input  wire logic              over_voltage_lockout,
    input  wire logic              under_voltage_lockout,
    input  wire logic              brown_out,
    input  wire logic              pdm_clk_err,
    // Extra event sources
    input  wire logic [7:0]        ext_event,
    // Interrupt outputs
    output logic                   irq,
    output logic                   event_out_n
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]        live_lo_reg;
    logic [7:0]        live_hi_reg;
    logic [7:0]        live_ext_reg;
    logic [7:0]        ltch_lo_reg;
    logic [7:0]        ltch_hi_reg;
    logic [7:0]        ltch_ext_reg;
    logic [7:0]        mask_lo_reg;
    logic [7:0]        mask_hi_reg;
    logic [7:0]        mask_ext_reg;
    logic [1:0]        pin_cfg_reg;
    logic              wait_reg;
    logic [BUS_W-1:0]  rdata_reg;
    logic              irq_reg;
    logic              event_n_reg;

    logic [7:0]        src_lo;
    logic [7:0]        src_hi;
    logic              acc;
    logic              aligned;
    logic [5:0]        idx;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        clr_lo;
    logic [7:0]        clr_hi;
    logic [7:0]        clr_ext;
    logic [7:0]        rd_byte;
    logic [23:0]       pend;

    assign src_lo = {lim_mute, lim_inf_hold, lim_max_atten, vbat_below_inflect,
                     lim_active, tdm_clk_err, over_current, over_temp};
    assign src_hi = {pdm_data_invalid, 3'h0, over_voltage_lockout,
                     under_voltage_lockout, brown_out, pdm_clk_err};

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One access per idle waitrequest; held requests are not taken twice
    assign acc     = (avs_read | avs_write) & wait_reg;
    assign aligned = (avs_address[1:0] == 2'h0);
    assign idx     = 6'(avs_address[ADDR_W-1:2]);
    assign wr_en   = acc & avs_write & avs_byteenable[0] & aligned;
    assign rd_en   = acc & avs_read & aligned;

    always_comb begin
        clr_lo  = 8'h00;
        clr_hi  = 8'h00;
        clr_ext = 8'h00;
        if (rd_en && idx == IDX_LTCH_LO) begin
            clr_lo = 8'hFF;
        end
        if (rd_en && idx == IDX_LTCH_HI) begin
            clr_hi = 8'hFF;
        end
        if (rd_en && idx == IDX_LTCH_EXT) begin
            clr_ext = 8'hFF;
        end
        if (wr_en && idx == IDX_LTCH_LO) begin
            clr_lo = avs_writedata[7:0];
        end
        if (wr_en && idx == IDX_LTCH_HI) begin
            clr_hi = avs_writedata[7:0];
        end
        if (wr_en && idx == IDX_LTCH_EXT) begin
            clr_ext = avs_writedata[7:0];
        end
    end

    always_comb begin
        case (idx)
            IDX_MASK_LO:  rd_byte = mask_lo_reg;
            IDX_MASK_HI:  rd_byte = mask_hi_reg;
            IDX_LIVE_LO:  rd_byte = live_lo_reg;
            IDX_LIVE_HI:  rd_byte = live_hi_reg;
            IDX_LTCH_LO:  rd_byte = ltch_lo_reg;
            IDX_LTCH_HI:  rd_byte = ltch_hi_reg;
            IDX_LTCH_EXT: rd_byte = ltch_ext_reg;
            IDX_PIN_CFG:  rd_byte = {6'h00, pin_cfg_reg};
            IDX_MASK_EXT: rd_byte = mask_ext_reg;
            default:      rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (acc) begin
            wait_reg  <= 1'b0;
            rdata_reg <= (avs_read && aligned) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else begin
            wait_reg  <= 1'b1;
        end
    end

    // ----------------------------------------
    // Live status
    // ----------------------------------------
    // One register stage; live reads only sample these
    always_ff @(posedge clk) begin
        if (rst) begin
            live_lo_reg  <= RST_STATUS;
            live_hi_reg  <= RST_STATUS;
            live_ext_reg <= RST_STATUS;
        end else begin
            live_lo_reg  <= src_lo;
            live_hi_reg  <= src_hi;
            live_ext_reg <= ext_event;
        end
    end

    // ----------------------------------------
    // Latched status
    // ----------------------------------------
    // Set wins over clear so an event during the clearing read is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            ltch_lo_reg  <= RST_STATUS;
            ltch_hi_reg  <= RST_STATUS;
            ltch_ext_reg <= RST_STATUS;
        end else begin
            ltch_lo_reg  <= (ltch_lo_reg & ~clr_lo) | live_lo_reg;
            ltch_hi_reg  <= ((ltch_hi_reg & ~clr_hi) | live_hi_reg) & HI_USED_BITS;
            ltch_ext_reg <= (ltch_ext_reg & ~clr_ext) | live_ext_reg;
        end
    end

    // ----------------------------------------
    // Masks and pin configuration
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_lo_reg  <= RST_MASK_LO;
            mask_hi_reg  <= RST_MASK_HI;
            mask_ext_reg <= RST_MASK_EXT;
            pin_cfg_reg  <= RST_PIN_CFG;
        end else if (wr_en) begin
            if (idx == IDX_MASK_LO) begin
                mask_lo_reg <= avs_writedata[7:0];
            end
            if (idx == IDX_MASK_HI) begin
                mask_hi_reg <= avs_writedata[7:0];
            end
            if (idx == IDX_MASK_EXT) begin
                mask_ext_reg <= avs_writedata[7:0];
            end
            if (idx == IDX_PIN_CFG) begin
                pin_cfg_reg <= avs_writedata[1:0];
            end
        end
    end

    // ----------------------------------------
    // Interrupt outputs
    // ----------------------------------------
    always_comb begin
        if (pin_cfg_reg[PIN_CFG_LATCHED]) begin
            pend = {ltch_ext_reg, ltch_hi_reg, ltch_lo_reg};
        end else begin
            pend = {live_ext_reg, live_hi_reg, live_lo_reg};
        end
        pend = pend & ~{mask_ext_reg, mask_hi_reg, mask_lo_reg};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg     <= 1'b0;
            event_n_reg <= 1'b1;
        end else begin
            irq_reg     <= |pend;
            event_n_reg <= ~|pend;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;
    assign irq             = irq_reg;
    assign event_out_n     = event_n_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_live_lo;
        1'b1 |=> live_lo_reg == $past(src_lo);
    endproperty
    a_live_lo: assert property (p_live_lo) else $error("live low mismatch");

    property p_live_hi;
        1'b1 |=> live_hi_reg == $past(src_hi) && live_hi_reg[6:4] == 3'h0;
    endproperty
    a_live_hi: assert property (p_live_hi) else $error("live high mismatch");

    property p_ltch_hold;
        (clr_lo == 8'h00) |=> (ltch_lo_reg & $past(ltch_lo_reg)) == $past(ltch_lo_reg);
    endproperty
    a_ltch_hold: assert property (p_ltch_hold) else $error("latched bit lost");

    property p_rd_clear;
        (rd_en && idx == IDX_LTCH_LO)
            |=> avs_readdata[7:0] == $past(ltch_lo_reg) && !avs_waitrequest
                && ltch_lo_reg == $past(live_lo_reg);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read clear wrong");

    property p_ltch_hi;
        1'b1 |=> ltch_hi_reg[6:4] == 3'h0
            && (ltch_hi_reg & $past(live_hi_reg)) == $past(live_hi_reg);
    endproperty
    a_ltch_hi: assert property (p_ltch_hi) else $error("latched high fields");

    property p_ext_set;
        live_ext_reg != 8'h00 |=> (ltch_ext_reg & $past(live_ext_reg)) == $past(live_ext_reg);
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("ext latch missed");

    property p_mask;
        pin_cfg_reg[PIN_CFG_LATCHED]
            && ({ltch_ext_reg, ltch_hi_reg, ltch_lo_reg}
                & ~{mask_ext_reg, mask_hi_reg, mask_lo_reg}) == 24'h00_0000
            |=> !irq && event_out_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source drove irq");

    property p_pin;
        1'b1 |=> event_out_n == !irq && irq == $past(|pend);
    endproperty
    a_pin: assert property (p_pin) else $error("pin disagrees with pending");

    property p_live_read;
        (rd_en && idx == IDX_LIVE_LO) |=> ltch_lo_reg == ($past(ltch_lo_reg) | $past(live_lo_reg));
    endproperty
    a_live_read: assert property (p_live_read) else $error("live read had effect");

    property p_wait;
        acc |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest timing");

    // Unmasked pending bits must reach the pin in either source mode
    property p_ltch_mode;
        pin_cfg_reg[PIN_CFG_LATCHED]
            && ({ltch_ext_reg, ltch_hi_reg, ltch_lo_reg}
                & ~{mask_ext_reg, mask_hi_reg, mask_lo_reg}) != 24'h00_0000
            |=> irq && !event_out_n;
    endproperty
    a_ltch_mode: assert property (p_ltch_mode) else $error("latched irq missed");

    property p_live_mode;
        !pin_cfg_reg[PIN_CFG_LATCHED]
            && ({live_ext_reg, live_hi_reg, live_lo_reg}
                & ~{mask_ext_reg, mask_hi_reg, mask_lo_reg}) != 24'h00_0000
            |=> irq && !event_out_n;
    endproperty
    a_live_mode: assert property (p_live_mode) else $error("live irq missed");

    property p_rdata_zero;
        !avs_waitrequest |-> avs_readdata[BUS_W-1:REG_W] == 24'h00_0000;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("upper read bits set");

    property p_be_ignored;
        (acc && avs_write && !avs_byteenable[0])
            |=> mask_lo_reg == $past(mask_lo_reg) && pin_cfg_reg == $past(pin_cfg_reg);
    endproperty
    a_be_ignored: assert property (p_be_ignored) else $error("lane 0 off write took");

    property p_mask_wr;
        (wr_en && idx == IDX_MASK_LO) |=> mask_lo_reg == $past(avs_writedata[7:0]);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    property p_ltch_hi_rd;
        (rd_en && idx == IDX_LTCH_HI)
            |=> avs_readdata[7:0] == $past(ltch_hi_reg)
                && ltch_hi_reg == ($past(live_hi_reg) & HI_USED_BITS);
    endproperty
    a_ltch_hi_rd: assert property (p_ltch_hi_rd) else $error("high read clear");

    property p_ltch_ext_rd;
        (rd_en && idx == IDX_LTCH_EXT)
            |=> avs_readdata[7:0] == $past(ltch_ext_reg)
                && ltch_ext_reg == $past(live_ext_reg);
    endproperty
    a_ltch_ext_rd: assert property (p_ltch_ext_rd) else $error("ext read clear");

endmodule

`default_nettype wire

// [include/ais_pkg.sv]
// Package for the amplifier interrupt status readback block.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
package ais_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [5:0] IDX_MASK_LO     = 6'h20;
    localparam logic [5:0] IDX_MASK_HI     = 6'h21;
    localparam logic [5:0] IDX_LIVE_LO     = 6'h22;
    localparam logic [5:0] IDX_LIVE_HI     = 6'h23;
    localparam logic [5:0] IDX_LTCH_LO     = 6'h24;
    localparam logic [5:0] IDX_LTCH_HI     = 6'h25;
    localparam logic [5:0] IDX_LTCH_EXT    = 6'h26;
    localparam logic [5:0] IDX_PIN_CFG     = 6'h30;
    localparam logic [5:0] IDX_MASK_EXT    = 6'h31;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_MASK_LO     = 8'hFC;
    localparam logic [7:0] RST_MASK_HI     = 8'hB1;
    localparam logic [7:0] RST_MASK_EXT    = 8'hFF;
    localparam logic [7:0] RST_STATUS      = 8'h00;
    localparam logic [1:0] RST_PIN_CFG     = 2'h1;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam logic [7:0] HI_USED_BITS    = 8'h8F;
    localparam int         PIN_CFG_LATCHED = 0;
    localparam int         REG_W           = 8;
    localparam int         BUS_W           = 32;

endpackage

// [verification/ais_host_model.sv]
// Host processor model: counts assertions of the active-low interrupt pin.
// Assumes the pin is a registered level in the block's clock domain.
`timescale 1ns/1ps
`default_nettype none
module ais_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Interrupt pin
    input  wire logic event_out_n,
    output var  int   irq_edges
);
    logic pin_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_reg   <= 1'b1;
            irq_edges <= 0;
        end else begin
            pin_reg <= event_out_n;
            if (pin_reg && !event_out_n) begin
                irq_edges <= irq_edges + 1;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb_amp_interrupt_status_readback.sv]
// Self-checking bench for the interrupt status readback block.
// Assumes ais_top, ais_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_amp_interrupt_status_readback;
    import ais_pkg::*;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq, event_out_n;
    logic [7:0]  avs_address, lo, ex, v, w, acc_lo, acc_hi;
    logic [4:0]  hi;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0]  expq[$];
    int          err_count, samples_checked, irq_edges, exp_edges;

    ais_top ais_top_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lim_mute(lo[7]),
        .lim_inf_hold(lo[6]), .lim_max_atten(lo[5]), .vbat_below_inflect(lo[4]),
        .lim_active(lo[3]), .tdm_clk_err(lo[2]), .over_current(lo[1]), .over_temp(lo[0]),
        .pdm_data_invalid(hi[4]), .over_voltage_lockout(hi[3]), .under_voltage_lockout(hi[2]),
        .brown_out(hi[1]), .pdm_clk_err(hi[0]), .ext_event(ex), .irq(irq),
        .event_out_n(event_out_n));
    ais_host_model ais_host_model_i (.clk(clk), .rst(rst), .event_out_n(event_out_n),
        .irq_edges(irq_edges));

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task miss(input string m);
        $display("mismatch at %0t: %s", $time, m);
        err_count++;
    endtask

    task end_sim;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk_irq(input logic e);
        samples_checked++;
        if (irq !== e || event_out_n !== !e) miss("interrupt level");
    endtask

    // Read monitor: each answered read takes the oldest expected value
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            samples_checked++;
            if (expq.size() == 0) miss("unexpected read answer");
            else if (avs_readdata !== {24'h000000, expq.pop_front()}) miss("read data");
        end
    end

    // ----------------------------------------
    // Avalon master
    // ----------------------------------------
    // No cycle limit here: a stuck slave is caught by the watchdog
    task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [5:0] idx, input logic [7:0] e);
        expq.push_back(e);
        acc(1'b0, idx, 8'h00);
    endtask

    task pulse_lo(input logic [7:0] s);
        lo <= s;
        @(posedge clk);
        lo <= 8'h00;
        repeat (5) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #20000;
        miss("watchdog");
        end_sim;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
        avs_writedata = 32'h00000000; avs_byteenable = 4'hF;
        lo = 8'h00; hi = 5'h00; ex = 8'h00; acc_lo = 8'h00; acc_hi = 8'h00;
        err_count = 0; samples_checked = 0;
        void'($urandom(32'hBC49));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(IDX_LIVE_HI, RST_STATUS);
        rd(IDX_LTCH_LO, RST_STATUS);
        rd(IDX_LTCH_HI, RST_STATUS);
        rd(IDX_LTCH_EXT, RST_STATUS);
        rd(6'h3F, 8'h00);
        rd(IDX_MASK_HI, RST_MASK_HI);
        rd(IDX_MASK_EXT, RST_MASK_EXT);
        rd(IDX_PIN_CFG, {6'h00, RST_PIN_CFG});
        chk_irq(1'b0);
        // Random live levels, held for the read; latched bits accumulate
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            w = 8'($urandom);
            lo <= v;
            hi <= w[4:0];
            acc_lo = acc_lo | v;
            acc_hi = acc_hi | {w[4], 3'b000, w[3:0]};
            repeat (2) @(posedge clk);
            rd(IDX_LIVE_LO, v);
            rd(IDX_LIVE_HI, {w[4], 3'b000, w[3:0]});
        end
        lo <= 8'h00;
        hi <= 5'h00;
        w = 8'($urandom);
        ex <= w;
        @(posedge clk);
        ex <= 8'h00;
        repeat (4) @(posedge clk);
        // Loop raises the pin once only if some random bit was unmasked at reset
        exp_edges = ((acc_lo & ~RST_MASK_LO) | (acc_hi & ~RST_MASK_HI)) != 8'h00 ? 3 : 2;
        chk_irq(exp_edges == 3);
        acc(1'b1, IDX_LIVE_HI, 8'hFF);
        rd(IDX_LIVE_HI, 8'h00);
        rd(IDX_LIVE_LO, 8'h00);
        rd(IDX_LTCH_LO, acc_lo);
        rd(IDX_LTCH_LO, 8'h00);
        rd(IDX_LTCH_HI, acc_hi);
        rd(IDX_LTCH_HI, 8'h00);
        rd(IDX_LTCH_EXT, w);
        rd(IDX_LTCH_EXT, 8'h00);
        // Writing ones clears only those latched bits
        ex <= 8'hA5;
        @(posedge clk);
        ex <= 8'h00;
        repeat (3) @(posedge clk);
        acc(1'b1, IDX_LTCH_EXT, 8'h0F);
        rd(IDX_LTCH_EXT, 8'hA0);
        // Unmasked over-current raises the pin until the cause is read
        pulse_lo(8'h02);
        chk_irq(1'b1);
        rd(IDX_LTCH_LO, 8'h02);
        repeat (3) @(posedge clk);
        chk_irq(1'b0);
        acc(1'b1, IDX_MASK_LO, 8'hFF);
        pulse_lo(8'h02);
        chk_irq(1'b0);
        rd(IDX_LTCH_LO, 8'h02);
        // Live mode: pin follows the level, an active source re-sets its flag
        acc(1'b1, IDX_PIN_CFG, 8'h00);
        rd(IDX_PIN_CFG, 8'h00);
        acc(1'b1, IDX_MASK_LO, 8'hFE);
        lo <= 8'h01;
        repeat (4) @(posedge clk);
        chk_irq(1'b1);
        rd(IDX_LTCH_LO, 8'h01);
        rd(IDX_LTCH_LO, 8'h01);
        lo <= 8'h00;
        repeat (4) @(posedge clk);
        chk_irq(1'b0);
        // Write without byte lane 0 leaves the mask alone
        avs_byteenable <= 4'h0;
        acc(1'b1, IDX_MASK_LO, 8'h00);
        avs_byteenable <= 4'hF;
        rd(IDX_MASK_LO, 8'hFE);
        samples_checked++;
        if (irq_edges != exp_edges) miss("interrupt pin edge count");
        end_sim;
    end
endmodule
`default_nettype wire
